// >>> logic/smav_pkg.sv
package smav_pkg;

  // Data path widths.
  localparam int SMP_W = 24;
  localparam int OUT_W = 16;
  localparam int AVG_W = 18;
  localparam int GAIN_W = 16;
  localparam int GAIN_FRAC = 8;
  localparam int PROD_W = SMP_W + GAIN_W + 1;
  localparam int FREQ_W = 32;
  localparam int HARM_W = 8;
  localparam int FDET_W = FREQ_W + HARM_W;

  // Sliding window geometry.
  localparam int DEPTH = 4096;
  localparam int PTR_W = 12;
  localparam int LEN_W = 13;
  localparam int SUM_W = AVG_W + PTR_W + 1;
  localparam int RECIP_FRAC = 24;
  localparam int RECIP_W = 25;
  localparam logic [RECIP_W-1:0] RECIP_ONE = 25'h100_0000;

  // Sample rate of the incoming stream and the averaging frequency limit.
  localparam logic [FDET_W-1:0] SAMPLE_HZ = 40'h00_0004_C4B4;
  localparam logic [FDET_W-1:0] MHZ_PER_HZ = 40'h00_0000_03E8;
  localparam logic [FDET_W-1:0] FAULT_FREQ_HZ = 40'h00_0000_12C0;
  localparam logic [FDET_W-1:0] FAULT_FREQ_MHZ = FAULT_FREQ_HZ * MHZ_PER_HZ;
  localparam logic [FDET_W-1:0] PERIOD_NUM = SAMPLE_HZ * MHZ_PER_HZ;

  // Full scale (10 V) and the wider range the averager accepts.
  localparam logic signed [OUT_W-1:0] FS_OUT = 16'sh7FFF;
  localparam logic signed [AVG_W-1:0] AVG_MAX = 18'sh1FFFF;

  // Register map, byte addresses.
  localparam int ADR_W = 8;
  localparam logic [ADR_W-1:0] ADR_CTRL = 8'h00;
  localparam logic [ADR_W-1:0] ADR_SENS = 8'h04;
  localparam logic [ADR_W-1:0] ADR_HARM = 8'h08;
  localparam logic [ADR_W-1:0] ADR_STATUS = 8'h0C;
  localparam logic [ADR_W-1:0] ADR_IRQ_STAT = 8'h10;
  localparam logic [ADR_W-1:0] ADR_IRQ_MASK = 8'h14;
  localparam logic [ADR_W-1:0] ADR_PERIOD = 8'h18;

  // Field layouts and reset values.
  localparam int CTRL_W = 3;
  localparam int CTRL_EN = 0;
  localparam int CTRL_DUAL = 1;
  localparam int CTRL_PHASE = 2;
  localparam logic [CTRL_W-1:0] CTRL_RST = 3'h0;
  localparam logic [GAIN_W-1:0] SENS_RST = 16'h0100;
  localparam int HARM_N1_LSB = 0;
  localparam int HARM_N2_LSB = 8;
  localparam logic [2*HARM_W-1:0] HARM_RST = 16'h0101;
  localparam int STAT_W = 6;
  localparam int ST_FAULT = 0;
  localparam int ST_OVX = 1;
  localparam int ST_OVY = 2;
  localparam int ST_OVM = 3;
  localparam int ST_ACTIVE = 4;
  localparam int ST_SETTLED = 5;
  localparam int IRQ_W = 3;
  localparam int IRQ_FAULT = 0;
  localparam int IRQ_OVLD = 1;
  localparam int IRQ_SETTLE = 2;
  localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

  typedef logic signed [SMP_W-1:0] smav_raw_t;
  typedef logic signed [AVG_W-1:0] smav_avg_t;
  typedef logic signed [OUT_W-1:0] smav_out_t;

  typedef struct packed {
    smav_raw_t x;
    smav_raw_t y;
    smav_raw_t mag;
  } smav_xym_t;

  typedef struct packed {
    smav_out_t x;
    smav_out_t y;
    smav_out_t mag;
  } smav_res_t;

  typedef struct packed {
    logic x;
    logic y;
    logic mag;
  } smav_flag_t;

endpackage

// >>> logic/smav_win.sv
`timescale 1ns/1ps
`default_nettype none

module smav_win (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Control.
  input wire logic restart_i,
  input wire logic avg_on_i,
  input wire logic [smav_pkg::LEN_W-1:0] len_i,
  input wire logic [smav_pkg::RECIP_W-1:0] recip_i,
  // Sample stream.
  input wire logic smp_vld_i,
  input wire smav_pkg::smav_avg_t smp_i,
  output smav_pkg::smav_avg_t res_o,
  output logic res_vld_o,
  output logic full_o
);
  import smav_pkg::*;

  smav_avg_t mem [DEPTH];
  logic [PTR_W-1:0] wr_ff;
  logic [LEN_W-1:0] fill_ff;
  logic signed [SUM_W-1:0] sum_ff;

  wire logic [LEN_W-1:0] wr_inc_w = LEN_W'(wr_ff) + LEN_W'(1);
  wire logic full_w = (fill_ff == len_i);
  wire smav_avg_t old_w = full_w ? mem[wr_ff] : '0;
  // Oldest sample leaves as the newest enters.
  wire logic signed [SUM_W-1:0] nxt_sum =
    sum_ff + SUM_W'(smp_i) - SUM_W'(old_w);
  wire logic signed [SUM_W+RECIP_W:0] prod_w =
    nxt_sum * $signed({1'b0, recip_i});
  // Dividing by the length is a multiply by its reciprocal.
  wire smav_avg_t mean_w = AVG_W'(prod_w >>> RECIP_FRAC);
  wire logic [PTR_W-1:0] nxt_wr =
    (wr_inc_w == len_i) ? '0 : wr_inc_w[PTR_W-1:0];

  assign full_o = full_w;

  always_ff @(posedge clk_i) begin
    if (smp_vld_i && !restart_i) begin
      mem[wr_ff] <= smp_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || restart_i) begin
      wr_ff <= '0;
      fill_ff <= '0;
      sum_ff <= '0;
    end else if (smp_vld_i) begin
      wr_ff <= nxt_wr;
      fill_ff <= full_w ? fill_ff : fill_ff + LEN_W'(1);
      sum_ff <= nxt_sum;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      res_o <= '0;
      res_vld_o <= 1'b0;
    end else begin
      res_vld_o <= smp_vld_i;
      if (smp_vld_i) begin
        res_o <= avg_on_i ? mean_w : smp_i;
      end
    end
  end

  chk_bypass_pass: assert property (@(posedge clk_i) disable iff (rst_i)
    (smp_vld_i && !avg_on_i) |=> (res_vld_o && res_o == $past(smp_i)))
    else $error("Bypassed sample did not pass through unchanged.");

  chk_restart_empty: assert property (@(posedge clk_i) disable iff (rst_i)
    restart_i |=> (!full_o && sum_ff == '0))
    else $error("Window was not emptied after a restart.");

endmodule

`default_nettype wire

// >>> logic/smav_top.sv
// The address map and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module smav_top (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Classic Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [smav_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Filtered sample stream and phase.
  input wire logic smp_vld_i,
  input wire smav_pkg::smav_xym_t smp_i,
  input wire smav_pkg::smav_out_t phase_i,
  // Reference frequencies in millihertz.
  input wire logic [smav_pkg::FREQ_W-1:0] freq_ref_i,
  input wire logic [smav_pkg::FREQ_W-1:0] freq_int_i,
  input wire logic [smav_pkg::FREQ_W-1:0] freq_ext_i,
  // Scaled outputs.
  output smav_pkg::smav_res_t out_o,
  output smav_pkg::smav_out_t second_analog_output_o,
  output smav_pkg::smav_flag_t ovld_o,
  output logic out_vld_o,
  output logic sync_fault_o,
  output logic avg_active_o,
  // Noise estimator feed.
  output smav_pkg::smav_out_t noise_x_o,
  output smav_pkg::smav_out_t noise_y_o,
  // Unscaled results for chart and host.
  output smav_pkg::smav_xym_t raw_o,
  output logic raw_vld_o,
  // Interrupt.
  output logic irq_o
);
  import smav_pkg::*;

  function automatic smav_avg_t sat_avg(input logic signed [PROD_W-1:0] v);
    if (v > PROD_W'(AVG_MAX)) begin
      return AVG_MAX;
    end else if (v < -PROD_W'(AVG_MAX)) begin
      return -AVG_MAX;
    end
    return AVG_W'(v);
  endfunction

  function automatic logic over_fs(input smav_avg_t v);
    return (v > AVG_W'(FS_OUT)) || (v < -AVG_W'(FS_OUT));
  endfunction

  function automatic smav_out_t clamp_fs(input smav_avg_t v);
    if (v > AVG_W'(FS_OUT)) begin
      return FS_OUT;
    end else if (v < -AVG_W'(FS_OUT)) begin
      return -FS_OUT;
    end
    return OUT_W'(v);
  endfunction

  logic [CTRL_W-1:0] ctrl_ff;
  logic [CTRL_W-1:0] mode_d_ff;
  logic [GAIN_W-1:0] sens_ff;
  logic [2*HARM_W-1:0] harm_ff;
  logic [IRQ_W-1:0] irq_stat_ff;
  logic [IRQ_W-1:0] irq_mask_ff;
  logic [LEN_W-1:0] len_ff;
  logic [RECIP_W-1:0] recip_ff;
  smav_avg_t s1_x_ff;
  smav_avg_t s1_y_ff;
  smav_avg_t s1_m_ff;
  smav_out_t ph_ff;
  logic s1_vld_ff;
  logic avg_ovld_ff;
  logic full_d_ff;

  // Register bus decode.
  wire logic wb_req_w = wb_cyc_i && wb_stb_i;
  wire logic wr_fire_w = wb_req_w && wb_we_i && wb_ack_o;
  wire logic [31:0] be_w = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                            {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire logic [31:0] wmask_w = wb_dat_i & be_w;
  wire logic wr_ctrl_w = wr_fire_w && (wb_adr_i == ADR_CTRL);
  wire logic wr_sens_w = wr_fire_w && (wb_adr_i == ADR_SENS);
  wire logic wr_harm_w = wr_fire_w && (wb_adr_i == ADR_HARM);
  wire logic wr_stat_w = wr_fire_w && (wb_adr_i == ADR_IRQ_STAT);
  wire logic wr_mask_w = wr_fire_w && (wb_adr_i == ADR_IRQ_MASK);

  wire logic [CTRL_W-1:0] nxt_ctrl =
    CTRL_W'((32'(ctrl_ff) & ~be_w) | wmask_w);
  wire logic [GAIN_W-1:0] nxt_sens =
    GAIN_W'((32'(sens_ff) & ~be_w) | wmask_w);
  wire logic [2*HARM_W-1:0] nxt_harm =
    (2*HARM_W)'((32'(harm_ff) & ~be_w) | wmask_w);
  wire logic [IRQ_W-1:0] nxt_mask =
    IRQ_W'((32'(irq_mask_ff) & ~be_w) | wmask_w);

  wire logic en_w = ctrl_ff[CTRL_EN];
  wire logic dual_w = ctrl_ff[CTRL_DUAL];

  // Averaging frequency selection.
  wire logic [HARM_W-1:0] n1_w = harm_ff[HARM_N1_LSB +: HARM_W];
  wire logic [HARM_W-1:0] n2_w = harm_ff[HARM_N2_LSB +: HARM_W];
  wire logic [FDET_W-1:0] f_in_w = FDET_W'(freq_int_i) * FDET_W'(n1_w);
  wire logic [FDET_W-1:0] f_ex_w = FDET_W'(freq_ext_i) * FDET_W'(n2_w);
  wire logic [FDET_W-1:0] f_dual_w =
    (f_in_w > f_ex_w) ? f_in_w - f_ex_w : f_ex_w - f_in_w;
  // The harmonic number plays no part outside dual mode.
  wire logic [FDET_W-1:0] f_sel_w =
    dual_w ? f_dual_w : FDET_W'(freq_ref_i);
  wire logic f_over_w = f_sel_w > FAULT_FREQ_MHZ;

  // Window length in samples; very low frequencies saturate at the depth.
  wire logic [FDET_W-1:0] len_raw_w =
    (f_sel_w == '0) ? FDET_W'(DEPTH) : PERIOD_NUM / f_sel_w;
  wire logic [LEN_W-1:0] len_w =
    (len_raw_w > FDET_W'(DEPTH)) ? LEN_W'(DEPTH) :
    (len_raw_w == '0) ? LEN_W'(1) : len_raw_w[LEN_W-1:0];
  wire logic [RECIP_W-1:0] nxt_recip = RECIP_ONE / RECIP_W'(len_ff);
  wire logic restart_w =
    (len_w != len_ff) || (ctrl_ff[CTRL_DUAL:CTRL_EN] !=
                          mode_d_ff[CTRL_DUAL:CTRL_EN]);

  // Sensitivity scaling ahead of the averager.
  wire logic signed [GAIN_W:0] gain_w = $signed({1'b0, sens_ff});
  wire logic signed [PROD_W-1:0] sc_x_w =
    (smp_i.x * gain_w) >>> GAIN_FRAC;
  wire logic signed [PROD_W-1:0] sc_y_w =
    (smp_i.y * gain_w) >>> GAIN_FRAC;
  wire logic signed [PROD_W-1:0] sc_m_w = (smp_i.mag * gain_w) >>> GAIN_FRAC;
  wire smav_avg_t sat_x_w = sat_avg(sc_x_w);
  wire smav_avg_t sat_y_w = sat_avg(sc_y_w);
  wire logic in_ovld_w =
    (sc_x_w != PROD_W'(sat_x_w)) || (sc_y_w != PROD_W'(sat_y_w));

  // The averagers sit behind the low-pass stage and feed the X and Y outputs; magnitude bypasses them.
  smav_avg_t res_x_w;
  smav_avg_t res_y_w;
  logic res_vld_w;
  logic win_full_w;

  smav_win u_win_x (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .restart_i(restart_w),
    .avg_on_i(avg_active_o),
    .len_i(len_ff),
    .recip_i(recip_ff),
    .smp_vld_i(s1_vld_ff),
    .smp_i(s1_x_ff),
    .res_o(res_x_w),
    .res_vld_o(res_vld_w),
    .full_o(win_full_w)
  );

  smav_win u_win_y (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .restart_i(restart_w),
    .avg_on_i(avg_active_o),
    .len_i(len_ff),
    .recip_i(recip_ff),
    .smp_vld_i(s1_vld_ff),
    .smp_i(s1_y_ff),
    .res_o(res_y_w),
    .res_vld_o(),
    .full_o()
  );

  // Output overload is judged on the result, apart from the fault.
  wire smav_flag_t nxt_ovld = '{x: over_fs(res_x_w), y: over_fs(res_y_w),
                                mag: over_fs(s1_m_ff)};
  wire logic nxt_fault = en_w && (f_over_w || avg_ovld_ff);
  wire logic settled_w = win_full_w && !full_d_ff;
  wire logic [IRQ_W-1:0] ev_w = {settled_w,
    res_vld_w && (nxt_ovld != '0), nxt_fault && !sync_fault_o};
  wire logic [IRQ_W-1:0] clr_w = wr_stat_w ? IRQ_W'(wmask_w) : '0;
  // A new event in the clearing cycle stays set.
  wire logic [IRQ_W-1:0] nxt_irq_stat = (irq_stat_ff & ~clr_w) | ev_w;

  logic [STAT_W-1:0] status_w;
  assign status_w[ST_FAULT] = sync_fault_o;
  assign status_w[ST_OVX] = ovld_o.x;
  assign status_w[ST_OVY] = ovld_o.y;
  assign status_w[ST_OVM] = ovld_o.mag;
  assign status_w[ST_ACTIVE] = avg_active_o;
  assign status_w[ST_SETTLED] = win_full_w;

  wire logic [31:0] rd_data_w =
    (wb_adr_i == ADR_CTRL) ? 32'(ctrl_ff) :
    (wb_adr_i == ADR_SENS) ? 32'(sens_ff) :
    (wb_adr_i == ADR_HARM) ? 32'(harm_ff) :
    (wb_adr_i == ADR_STATUS) ? 32'(status_w) :
    (wb_adr_i == ADR_IRQ_STAT) ? 32'(irq_stat_ff) :
    (wb_adr_i == ADR_IRQ_MASK) ? 32'(irq_mask_ff) :
    (wb_adr_i == ADR_PERIOD) ? 32'(len_ff) : '0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_req_w && !wb_ack_o;
      if (wb_req_w && !wb_ack_o) begin
        wb_dat_o <= rd_data_w;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_ff <= CTRL_RST;
      sens_ff <= SENS_RST;
      harm_ff <= HARM_RST;
      irq_mask_ff <= IRQ_RST;
    end else begin
      ctrl_ff <= wr_ctrl_w ? nxt_ctrl : ctrl_ff;
      sens_ff <= wr_sens_w ? nxt_sens : sens_ff;
      harm_ff <= wr_harm_w ? nxt_harm : harm_ff;
      irq_mask_ff <= wr_mask_w ? nxt_mask : irq_mask_ff;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_d_ff <= CTRL_RST;
      len_ff <= LEN_W'(DEPTH);
      recip_ff <= '0;
      avg_active_o <= 1'b0;
      sync_fault_o <= 1'b0;
      irq_stat_ff <= IRQ_RST;
      irq_o <= 1'b0;
      full_d_ff <= 1'b0;
    end else begin
      mode_d_ff <= ctrl_ff;
      len_ff <= len_w;
      recip_ff <= nxt_recip;
      avg_active_o <= en_w && !f_over_w;
      sync_fault_o <= nxt_fault;
      irq_stat_ff <= nxt_irq_stat;
      irq_o <= (irq_stat_ff & irq_mask_ff) != '0;
      full_d_ff <= win_full_w;
    end
  end

  // Input stage: raw copy, scaled samples and the pinned noise feed.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_vld_ff <= 1'b0;
      raw_vld_o <= 1'b0;
      raw_o <= '0;
      s1_x_ff <= '0;
      s1_y_ff <= '0;
      s1_m_ff <= '0;
      ph_ff <= '0;
      avg_ovld_ff <= 1'b0;
      noise_x_o <= '0;
      noise_y_o <= '0;
    end else begin
      s1_vld_ff <= smp_vld_i;
      raw_vld_o <= smp_vld_i;
      if (smp_vld_i) begin
        raw_o <= smp_i;
        s1_x_ff <= sat_x_w;
        s1_y_ff <= sat_y_w;
        s1_m_ff <= sat_avg(sc_m_w);
        ph_ff <= phase_i;
        avg_ovld_ff <= in_ovld_w;
        noise_x_o <= clamp_fs(sat_x_w);
        noise_y_o <= clamp_fs(sat_y_w);
      end
    end
  end

  // Output stage: full scale equals the sensitivity, beyond it pins.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_vld_o <= 1'b0;
      out_o <= '0;
      ovld_o <= '0;
      second_analog_output_o <= '0;
    end else begin
      out_vld_o <= res_vld_w;
      if (res_vld_w) begin
        out_o <= '{x: clamp_fs(res_x_w), y: clamp_fs(res_y_w),
                   mag: clamp_fs(s1_m_ff)};
        ovld_o <= nxt_ovld;
        second_analog_output_o <= ctrl_ff[CTRL_PHASE] ? ph_ff :
                                  clamp_fs(res_y_w);
      end
    end
  end

  chk_fault_freq: assert property (@(posedge clk_i) disable iff (rst_i)
    (en_w && !dual_w && f_over_w) |=> sync_fault_o)
    else $error("No sync fault above the reference limit.");

  chk_fault_dual: assert property (@(posedge clk_i) disable iff (rst_i)
    (en_w && dual_w && f_dual_w > FAULT_FREQ_MHZ) |=> sync_fault_o)
    else $error("No sync fault above the dual detect limit.");

  chk_fault_ovld: assert property (@(posedge clk_i) disable iff (rst_i)
    (en_w && smp_vld_i && in_ovld_w) |=> ##1 sync_fault_o)
    else $error("Averager overload did not raise sync fault.");

  chk_active_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    avg_active_o |-> $past(en_w && f_sel_w <= FAULT_FREQ_MHZ))
    else $error("Averaging active above the frequency limit.");

  chk_ovld_pin: assert property (@(posedge clk_i) disable iff (rst_i)
    (res_vld_w && res_x_w > AVG_W'(FS_OUT)) |=> (ovld_o.x && out_o.x == FS_OUT))
    else $error("Overloaded X not pinned and flagged.");

  chk_noise_pin: assert property (@(posedge clk_i) disable iff (rst_i)
    (smp_vld_i && sc_y_w < -PROD_W'(FS_OUT)) |=> noise_y_o == -FS_OUT)
    else $error("Noise feed not pinned at negative full scale.");

  chk_phase_map: assert property (@(posedge clk_i) disable iff (rst_i)
    (smp_vld_i && ctrl_ff[CTRL_PHASE]) ##2 ctrl_ff[CTRL_PHASE]
      |=> second_analog_output_o == $past(phase_i, 3))
    else $error("Phase output does not follow phase input.");

  chk_raw_keep: assert property (@(posedge clk_i) disable iff (rst_i)
    smp_vld_i |=> (raw_vld_o && raw_o == $past(smp_i)))
    else $error("Raw result altered or late.");

  chk_len_restart: assert property (@(posedge clk_i) disable iff (rst_i)
    (len_w != len_ff) |=> (len_ff == $past(len_w) && !win_full_w))
    else $error("Window length change did not restart the window.");

endmodule

`default_nettype wire

// >>> bench/smav_src.sv
`timescale 1ns/1ps
`default_nettype none

module smav_src (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Values to send; alt_i swings x up and down on alternate samples.
  input wire smav_pkg::smav_xym_t val_i,
  input wire smav_pkg::smav_raw_t alt_i,
  // Filtered stream towards the block.
  output logic vld_o = 1'b0,
  output smav_pkg::smav_xym_t smp_o = '0
);
  import smav_pkg::*;
  logic [2:0] cnt_ff = 3'h0;
  logic sgn_ff = 1'b0;
  wire logic fire = !rst_i && cnt_ff == 3'h5;
  // One sample every six cycles, well above the minimum spacing.
  always_ff @(posedge clk_i) begin
    cnt_ff <= (rst_i || fire) ? 3'h0 : cnt_ff + 3'h1;
    vld_o <= fire;
    sgn_ff <= rst_i ? 1'b0 : sgn_ff ^ fire;
    // Lines toggle between strobes so a late capture shows up.
    if (fire) begin
      smp_o <= {sgn_ff ? val_i.x - alt_i : val_i.x + alt_i,
                val_i.y, val_i.mag};
    end else begin
      smp_o <= ~smp_o;
    end
  end
endmodule

`default_nettype wire

// >>> bench/sync_moving_average_output_scaler_test.sv
`timescale 1ns/1ps
`default_nettype none

module sync_moving_average_output_scaler_test;
  import smav_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic ph_mode = 1'b0;
  logic [ADR_W-1:0] adr = '0;
  logic [31:0] wdat = '0;
  logic [31:0] rdat, dat_o;
  logic ack, svld, ovd, fault, act, rvld, irq;
  smav_xym_t val = '0;
  smav_xym_t smp, raw;
  smav_raw_t alt = '0;
  smav_out_t ph = '0;
  smav_out_t sec, nx, ny;
  smav_res_t outv;
  smav_flag_t ov;
  logic [FREQ_W-1:0] fref = 32'h0000_03E8;
  logic [FREQ_W-1:0] fint = '0;
  logic [FREQ_W-1:0] fext = '0;
  logic [31:0] lf = 32'hE332D6F5;
  logic [15:0] gain = 16'h0100;
  int failures = 0;
  int cmp_count = 0;
  int ticks = 0;
  int rv_n = 0;
  logic [ADR_W-1:0] ra [8] = '{ADR_CTRL, ADR_SENS, ADR_HARM, ADR_STATUS,
    ADR_IRQ_STAT, ADR_IRQ_MASK, ADR_PERIOD, 8'h1C};
  logic [31:0] rv [8] = '{32'h0, 32'h100, 32'h101, 32'h0, 32'h0, 32'h0,
    32'h1000, 32'h0};
  logic [63:0] dt [3] = '{64'h001E8480_000F4240, 64'h000F4240_004C4B40,
    64'h003D0900_000F4240};
  logic [31:0] dl [3] = '{32'h68, 32'h68, 32'h2C};

  smav_src u_smav_src (.clk_i(clk_i), .rst_i(rst_i), .val_i(val),
    .alt_i(alt), .vld_o(svld), .smp_o(smp));
  smav_top u_smav_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .smp_vld_i(svld), .smp_i(smp), .phase_i(ph), .freq_ref_i(fref),
    .freq_int_i(fint), .freq_ext_i(fext), .out_o(outv),
    .second_analog_output_o(sec), .ovld_o(ov), .out_vld_o(ovd),
    .sync_fault_o(fault), .avg_active_o(act), .noise_x_o(nx),
    .noise_y_o(ny), .raw_o(raw), .raw_vld_o(rvld), .irq_o(irq));

  initial begin
    forever #25 clk_i = ~clk_i;
  end

  function automatic logic [31:0] rnd();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf;
  endfunction

  function automatic logic signed [47:0] scl(smav_raw_t v);
    return (48'(v) * $signed({32'h0, gain})) >>> 8;
  endfunction

  function automatic logic signed [47:0] clp(logic signed [47:0] s);
    return s > 48'sh7FFF ? 48'sh7FFF : (s < -48'sh7FFF ? -48'sh7FFF : s);
  endfunction

  function automatic logic ovf(smav_raw_t v);
    return scl(v) != clp(scl(v));
  endfunction

  // Mean as the window forms it: truncated reciprocal, floor on shift.
  function automatic logic signed [47:0] avg(int c, int l);
    return (48'(c) * l * ((1 << 24) / l)) >>> 24;
  endfunction

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Raw strobes lead output strobes by two cycles, so the count is one
  // while an output strobe stands.
  always @(posedge clk_i) begin
    ticks <= ticks + 1;
    rv_n <= rv_n + int'(rvld) - int'(ovd);
    if (ticks == 20000) begin
      failures++;
      end_sim();
    end
  end

  task automatic chk(logic [71:0] seen, logic [71:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Ack and read data are taken at the rising edge that samples ack high,
  // and the request is released at that same edge.
  task automatic wb(logic w, logic [ADR_W-1:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc, we, adr, wdat} <= {1'b1, w, a, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    rdat = dat_o;
    cyc <= 1'b0;
    if (n >= 50) begin
      failures++;
      end_sim();
    end
  endtask

  task automatic rd(logic [ADR_W-1:0] a, logic [31:0] e);
    wb(1'b0, a, '0);
    chk(rdat, e);
  endtask

  task automatic sens(logic [15:0] g);
    gain = g;
    wb(1'b1, ADR_SENS, {16'h0, g});
  endtask

  task automatic smp_wait();
    int n;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (ovd !== 1'b1 && n < 20);
    if (n >= 20) begin
      failures++;
      end_sim();
    end
  endtask

  task automatic irq_chk(logic e);
    repeat (2) @(negedge clk_i);
    chk(irq, e);
  endtask

  task automatic pass_chk(int n);
    logic [31:0] r;
    smp_wait();
    repeat (n) begin
      smp_wait();
      chk(outv.x, clp(scl(val.x)));
      chk(outv.y, clp(scl(val.y)));
      chk(outv.mag, clp(scl(val.mag)));
      chk(ov, {ovf(val.x), ovf(val.y), ovf(val.mag)});
      chk(nx, clp(scl(val.x)));
      chk(ny, clp(scl(val.y)));
      chk(raw, val);
      chk(rv_n, 1);
      chk(sec, ph_mode ? ph : clp(scl(val.y)));
      chk({act, fault}, 2'b00);
      @(posedge clk_i);
      r = rnd();
      val <= {{6{r[17]}}, r[17:0], {6{r[31]}}, r[31:14], 8'h00, r[15:0]};
      ph <= (r[15:0] == 16'h8000) ? 16'h0000 : r[15:0];
    end
  endtask

  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (ra[i]) rd(ra[i], rv[i]);
    $display("Test reset done");
    sens(16'h0200);
    pass_chk(20);
    sens(16'h0100);
    wb(1'b1, ADR_CTRL, 32'h4);
    ph_mode = 1'b1;
    val <= {24'h007FFF, 24'hFF8001, 24'h008000};
    pass_chk(20);
    rd(ADR_IRQ_STAT, 32'h2);
    $display("Test scaling done");
    sens(16'h0200);
    fref <= 32'h002FAF08;
    alt <= 24'sh00012C;
    val <= {24'h0003E8, 24'hFFF830, 24'h0001F4};
    repeat (2) smp_wait();
    wb(1'b1, ADR_IRQ_STAT, 32'h7);
    wb(1'b1, ADR_CTRL, 32'h1);
    rd(ADR_PERIOD, 32'h64);
    repeat (110) smp_wait();
    chk(act, 1'b1);
    chk(outv.x, avg(2000, 100));
    chk(outv.y, avg(-4000, 100));
    chk(outv.mag, 48'sd1000);
    rd(ADR_IRQ_STAT, 32'h4);
    rd(ADR_STATUS, 32'h30);
    @(posedge clk_i);
    fref <= 32'h002540BE;
    repeat (5) smp_wait();
    rd(ADR_STATUS, 32'h10);
    rd(ADR_PERIOD, 32'h80);
    repeat (130) smp_wait();
    rd(ADR_STATUS, 32'h30);
    chk(outv.x, avg(2000, 128));
    irq_chk(1'b0);
    wb(1'b1, ADR_IRQ_MASK, 32'h4);
    irq_chk(1'b1);
    wb(1'b1, ADR_IRQ_STAT, 32'h4);
    irq_chk(1'b0);
    $display("Test averaging done");
    wb(1'b1, ADR_IRQ_MASK, 32'h1);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_i);
      fref <= 32'h00493E00 + i;
      repeat (3) smp_wait();
      chk(fault, i);
      chk(act, !i);
    end
    chk(irq, 1'b1);
    @(posedge clk_i);
    fref <= 32'h002FAF08;
    alt <= '0;
    sens(16'h0400);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_i);
      val.x <= 24'h008000 - i;
      repeat (110) smp_wait();
      chk(fault, !i);
      chk(ov.x, 1'b1);
    end
    $display("Test fault done");
    sens(16'h0100);
    fref <= 32'h00895440;
    wb(1'b1, ADR_HARM, 32'h0102);
    wb(1'b1, ADR_CTRL, 32'h3);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_i);
      {fint, fext} <= dt[i];
      repeat (3) smp_wait();
      rd(ADR_PERIOD, dl[i]);
      chk(fault, i == 2);
    end
    $display("Test dual done");
    end_sim();
  end
endmodule

`default_nettype wire
